/* File: verilog/fsp_device.sv */
/*
 * Fast serial port: register file, transmitter with optional RTS/CTS
 * handshake, receiver with byte FIFO or direct memory writes.
 * Assumes link pins are asynchronous and a memory accepts one write
 * per cycle without stalling.
 */
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps
module fsp_device #(
   parameter int FIFO_DEPTH = 4
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [15:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   output logic irq,
   output logic memWrEn,
   output logic [15:0] memAddr,
   output logic [7:0] memWrData,
   fsp_link_if.dev link
);
   localparam int PW = $clog2(FIFO_DEPTH);
   typedef enum logic [1:0] {S_IDLE = 2'b00, S_START = 2'b01, S_DATA = 2'b10,
      S_STOP = 2'b11} fsp_state_e;
   // ***************************************************
   // Registers
   // ***************************************************
   logic [2:0] ctrl_r; // Modes and handshake
   logic [15:0] gap_r; // tx_gap_value
   logic [15:0] rate_r; // baud_divisor_value
   logic [7:0] txHold_r; // Byte waiting to go
   logic txPend_r; // Byte accepted, not finished
   logic [fsp_pkg::EV_W-1:0] irqStat_r, irqMask_r, evSet;
   logic [15:0] blkAddr_r; // Next memory address
   logic wrHit, rdPop, rxDeliver, rxBad;
   logic [7:0] rxShift_r;
   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   logic [2:0] rxSync_r, ctsSync_r; // Three stages each
   logic rxLvl_r, ctsLvl_r; // Filtered levels
   // Shift pins in
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxSync_r <= 3'h7;
         ctsSync_r <= 3'h0;
      end else begin
         rxSync_r <= {rxSync_r[1:0], link.serialRxLine};
         ctsSync_r <= {ctsSync_r[1:0], link.clearToSendIn};
      end
   end
   // Accept a change once stages two and three agree
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxLvl_r <= 1'b1;
         ctsLvl_r <= 1'b0;
      end else begin
         if (rxSync_r[1] == rxSync_r[2]) rxLvl_r <= rxSync_r[2];
         if (ctsSync_r[1] == ctsSync_r[2]) ctsLvl_r <= ctsSync_r[2];
      end
   end
   // ***************************************************
   // Register writes
   // ***************************************************
   // Control registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ctrl_r <= fsp_pkg::CTRL_RESET;
         gap_r <= fsp_pkg::GAP_RESET;
         rate_r <= fsp_pkg::RATE_RESET;
         irqMask_r <= '0;
         blkAddr_r <= '0;
      end else begin
         if (regWr && regAddr == fsp_pkg::OFF_CTRL) ctrl_r <= regWrData[2:0];
         if (regWr && regAddr == fsp_pkg::OFF_GAP) gap_r <= regWrData;
         if (regWr && regAddr == fsp_pkg::OFF_RATE) rate_r <= regWrData;
         if (regWr && regAddr == fsp_pkg::OFF_IRQMASK) irqMask_r <= regWrData[fsp_pkg::EV_W-1:0];
         // Software write, else advance after each block byte
         if (regWr && regAddr == fsp_pkg::OFF_BLKADDR) blkAddr_r <= regWrData;
         else if (memWrEn) blkAddr_r <= blkAddr_r + 16'h0001;
      end
   end
   // Sticky events; a set beats a clear in the same cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) irqStat_r <= '0;
      else if (regWr && regAddr == fsp_pkg::OFF_IRQSTAT)
         irqStat_r <= (irqStat_r & ~regWrData[fsp_pkg::EV_W-1:0]) | evSet;
      else irqStat_r <= irqStat_r | evSet;
   end
   assign irq = |(irqStat_r & irqMask_r);
   // ***************************************************
   // Transmitter
   // ***************************************************
   fsp_state_e txState_r;
   logic [15:0] txCnt_r, stopLeft_r; // Clocks in bit, stop periods left
   logic [2:0] txBit_r;
   logic [7:0] txShift_r;
   logic txLine_r, rts_r;
   logic txEnd; // Last clock of a bit period
   logic hsEn;
   assign hsEn = ctrl_r[fsp_pkg::CTRL_HSEN];
   assign txEnd = (txCnt_r == 16'h0000);
   assign wrHit = regWr && regAddr == fsp_pkg::OFF_TXDATA && !txPend_r;
   // Hold register; a write while pending is ignored
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txHold_r <= '0;
         txPend_r <= 1'b0;
      end else if (wrHit) begin
         txHold_r <= regWrData[7:0];
         txPend_r <= 1'b1;
      end else if (txState_r == S_STOP && txEnd && stopLeft_r == 16'h0001) begin
         txPend_r <= 1'b0;
      end
   end
   // Request to send: raised while a byte waits, dropped in bit two
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) rts_r <= 1'b0;
      else if (txState_r == S_IDLE && txPend_r && hsEn) rts_r <= 1'b1;
      else if (txState_r == S_DATA && txBit_r == fsp_pkg::RTS_DROP_BIT) rts_r <= 1'b0;
   end
   // Frame sequencer
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         txState_r <= S_IDLE;
         txCnt_r <= '0;
         stopLeft_r <= '0;
         txBit_r <= '0;
         txShift_r <= '0;
         txLine_r <= 1'b1;
      end else begin
         case (txState_r)
            S_IDLE: begin
               txLine_r <= 1'b1;
               // Start only with handshake off or CTS seen high
               if (txPend_r && (!hsEn || (rts_r && ctsLvl_r))) begin
                  txState_r <= S_START;
                  txLine_r <= 1'b0;
                  txCnt_r <= rate_r;
                  txShift_r <= txHold_r;
               end
            end
            S_START: begin
               if (txEnd) begin
                  txState_r <= S_DATA;
                  txLine_r <= txShift_r[0];
                  txBit_r <= '0;
                  txCnt_r <= rate_r;
               end else txCnt_r <= txCnt_r - 16'h0001;
            end
            S_DATA: begin
               if (txEnd) begin
                  txCnt_r <= rate_r;
                  if (txBit_r == fsp_pkg::LAST_BIT) begin
                     txState_r <= S_STOP;
                     txLine_r <= 1'b1;
                     // Block mode stretches the stop bit
                     if (ctrl_r[fsp_pkg::CTRL_TXBLK] && gap_r > fsp_pkg::GAP_BIAS + 16'h0001)
                        stopLeft_r <= gap_r - fsp_pkg::GAP_BIAS;
                     else stopLeft_r <= 16'h0001;
                  end else begin
                     txBit_r <= txBit_r + 3'h1;
                     txLine_r <= txShift_r[txBit_r + 3'h1];
                  end
               end else txCnt_r <= txCnt_r - 16'h0001;
            end
            S_STOP: begin
               if (txEnd) begin
                  txCnt_r <= rate_r;
                  stopLeft_r <= stopLeft_r - 16'h0001;
                  if (stopLeft_r == 16'h0001) txState_r <= S_IDLE;
               end else txCnt_r <= txCnt_r - 16'h0001;
            end
            default: txState_r <= S_IDLE;
         endcase
      end
   end
   assign link.serialTxLine = txLine_r;
   assign link.requestToSendOut = rts_r;
   // ***************************************************
   // Receiver
   // ***************************************************
   fsp_state_e rxState_r;
   logic [15:0] rxCnt_r;
   logic [2:0] rxBit_r;
   // Sample each bit in its middle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rxState_r <= S_IDLE;
         rxCnt_r <= '0;
         rxBit_r <= '0;
         rxShift_r <= '0;
      end else begin
         case (rxState_r)
            S_IDLE: if (!rxLvl_r) begin
               rxState_r <= S_START;
               rxCnt_r <= {1'b0, rate_r[15:1]}; // Half period to centre
            end
            S_START: begin
               if (rxCnt_r != 16'h0000) rxCnt_r <= rxCnt_r - 16'h0001;
               else if (rxLvl_r) rxState_r <= S_IDLE; // Glitch, not a start
               else begin
                  rxState_r <= S_DATA;
                  rxCnt_r <= rate_r;
                  rxBit_r <= '0;
               end
            end
            S_DATA: begin
               if (rxCnt_r != 16'h0000) rxCnt_r <= rxCnt_r - 16'h0001;
               else begin
                  rxShift_r <= {rxLvl_r, rxShift_r[7:1]};
                  rxCnt_r <= rate_r;
                  rxBit_r <= rxBit_r + 3'h1;
                  if (rxBit_r == fsp_pkg::LAST_BIT) rxState_r <= S_STOP;
               end
            end
            S_STOP: begin
               if (rxCnt_r != 16'h0000) rxCnt_r <= rxCnt_r - 16'h0001;
               else rxState_r <= S_IDLE;
            end
            default: rxState_r <= S_IDLE;
         endcase
      end
   end
   assign rxDeliver = rxState_r == S_STOP && rxCnt_r == 16'h0000 && rxLvl_r;
   assign rxBad = rxState_r == S_STOP && rxCnt_r == 16'h0000 && !rxLvl_r;
   // ***************************************************
   // Receive FIFO and memory path
   // ***************************************************
   logic [7:0] fifo_r [FIFO_DEPTH];
   logic [PW-1:0] wrPtr_r, rdPtr_r;
   logic [PW:0] fill_r;
   logic fifoPush, fifoFull, fifoEmpty, blkRx;
   assign blkRx = ctrl_r[fsp_pkg::CTRL_RXBLK];
   assign fifoFull = fill_r == (PW+1)'(FIFO_DEPTH);
   assign fifoEmpty = fill_r == '0;
   assign fifoPush = rxDeliver && !blkRx && !fifoFull;
   assign rdPop = regRd && regAddr == fsp_pkg::OFF_RXDATA && !fifoEmpty;
   // Storage and pointers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wrPtr_r <= '0;
         rdPtr_r <= '0;
         fill_r <= '0;
      end else begin
         if (fifoPush) wrPtr_r <= (wrPtr_r == PW'(FIFO_DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
         if (rdPop) rdPtr_r <= (rdPtr_r == PW'(FIFO_DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
         fill_r <= fill_r + {{PW{1'b0}}, fifoPush} - {{PW{1'b0}}, rdPop};
      end
   end
   always_ff @(posedge clk) begin
      if (fifoPush) fifo_r[wrPtr_r] <= rxShift_r;
   end
   // Block mode writes straight to memory
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         memWrEn <= 1'b0;
         memWrData <= '0;
      end else begin
         memWrEn <= rxDeliver && blkRx;
         if (rxDeliver && blkRx) memWrData <= rxShift_r;
      end
   end
   assign memAddr = blkAddr_r;
   always_comb begin
      evSet = '0;
      evSet[fsp_pkg::EV_RX] = rxDeliver;
      evSet[fsp_pkg::EV_TXDONE] = txState_r == S_STOP && txEnd && stopLeft_r == 16'h0001;
      evSet[fsp_pkg::EV_FRAME] = rxBad;
      evSet[fsp_pkg::EV_OVERRUN] = rxDeliver && !blkRx && fifoFull;
   end
   // ***************************************************
   // Register reads, data one cycle after strobe
   // ***************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) regRdData <= '0;
      else if (regRd) begin
         case (regAddr)
            fsp_pkg::OFF_CTRL: regRdData <= {13'h0000, ctrl_r};
            fsp_pkg::OFF_GAP: regRdData <= gap_r;
            fsp_pkg::OFF_RATE: regRdData <= rate_r;
            fsp_pkg::OFF_TXDATA: regRdData <= {8'h00, txHold_r};
            fsp_pkg::OFF_RXDATA: regRdData <= fifoEmpty ? 16'h0000 : {8'h00, fifo_r[rdPtr_r]};
            fsp_pkg::OFF_STATUS: regRdData <= {14'h0000, txPend_r, !fifoEmpty};
            fsp_pkg::OFF_IRQSTAT: regRdData <= {12'h000, irqStat_r};
            fsp_pkg::OFF_IRQMASK: regRdData <= {12'h000, irqMask_r};
            fsp_pkg::OFF_BLKADDR: regRdData <= blkAddr_r;
            default: regRdData <= 16'h0000;
         endcase
      end else regRdData <= 16'h0000;
   end
endmodule : fsp_device

/* File: verilog/fsp_pkg.sv */
/*
 * Constants used by the port end of the fast serial port link and its bench.
 * Assumes one 25 MHz clock; software reaches the device registers
 * over a plain address/strobe port with 16-bit data.
 */
package fsp_pkg;
   // ***************************************************
   // Register offsets (byte addresses)
   // ***************************************************
   localparam logic [15:0] OFF_CTRL = 16'hc070; // Mode and handshake control
   localparam logic [15:0] OFF_GAP = 16'hc074; // transmit_gap_length
   localparam logic [15:0] OFF_RATE = 16'hc078; // baud_divisor_value
   localparam logic [15:0] OFF_TXDATA = 16'hc07c; // Byte to send
   localparam logic [15:0] OFF_RXDATA = 16'hc080; // Receive FIFO head, pops
   localparam logic [15:0] OFF_STATUS = 16'hc084; // Live state
   localparam logic [15:0] OFF_IRQSTAT = 16'hc088; // Sticky events, write 1 clears
   localparam logic [15:0] OFF_IRQMASK = 16'hc08c; // Event enables
   localparam logic [15:0] OFF_BLKADDR = 16'hc090; // Block receive memory pointer
   // ***************************************************
   // Field positions
   // ***************************************************
   localparam int CTRL_TXBLK = 0; // Transmit block mode
   localparam int CTRL_RXBLK = 1; // Receive block mode
   localparam int CTRL_HSEN = 2; // Hardware handshake enable
   localparam int ST_RXWAIT = 0; // rx_byte_waiting
   localparam int ST_TXPEND = 1; // Byte pending or being sent
   localparam int EV_RX = 0; // Byte received
   localparam int EV_TXDONE = 1; // Character finished
   localparam int EV_FRAME = 2; // Bad stop bit
   localparam int EV_OVERRUN = 3; // FIFO full, byte lost
   localparam int EV_W = 4; // Event count
   // ***************************************************
   // Reset values and counts
   // ***************************************************
   localparam logic [15:0] GAP_RESET = 16'h000b; // Gives a two bit period stop
   localparam logic [15:0] GAP_BIAS = 16'h0009; // Stop = gap minus this
   localparam logic [15:0] RATE_RESET = 16'h0017; // Bit period = value + 1 clocks
   localparam logic [2:0] CTRL_RESET = 3'h0;
   localparam logic [2:0] RTS_DROP_BIT = 3'h2; // Third data bit
   localparam logic [2:0] LAST_BIT = 3'h7;
endpackage : fsp_pkg

/* File: verilog/fsp_link_if.sv */
/*
 * Serial link between the port and its remote peer.
 * Assumes both ends share clk; pins are plain levels.
 */
`timescale 1ns/100ps
interface fsp_link_if;
   logic serialTxLine; // Port to peer data, idles high
   logic serialRxLine; // Peer to port data, idles high
   logic clearToSendIn; // Peer allows port to send
   logic requestToSendOut; // Port wants to send
   modport dev (output serialTxLine, input serialRxLine,
      input clearToSendIn, output requestToSendOut);
   modport peer (input serialTxLine, output serialRxLine,
      output clearToSendIn, input requestToSendOut);
endinterface : fsp_link_if

/* File: verilog/fsp_peer.sv */
/*
 * Remote peer end: sends and receives framed bytes and runs the
 * CTS side of the handshake.
 * Assumes the same bit period as the port; link pins are asynchronous.
 */
`timescale 1ns/100ps
module fsp_peer #(
   parameter logic [15:0] DIVISOR = 16'h0017
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [7:0] sendData,
   input wire logic sendValid,
   output logic sendReady,
   output logic [7:0] recvData,
   output logic recvValid,
   output logic recvFrameErr,
   input wire logic holdOff,
   fsp_link_if.peer link
);
   logic [2:0] dSync_r, rSync_r;
   logic dLvl_r, rtsLvl_r, cts_r;
   // ***************************************************
   // Pin synchronisers
   // ***************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dSync_r <= 3'h7;
         rSync_r <= 3'h0;
         dLvl_r <= 1'b1;
         rtsLvl_r <= 1'b0;
      end else begin
         dSync_r <= {dSync_r[1:0], link.serialTxLine};
         rSync_r <= {rSync_r[1:0], link.requestToSendOut};
         if (dSync_r[1] == dSync_r[2]) dLvl_r <= dSync_r[2];
         if (rSync_r[1] == rSync_r[2]) rtsLvl_r <= rSync_r[2];
      end
   end
   // ***************************************************
   // Clear to send
   // ***************************************************
   // Low while holding; once raised under RTS kept until RTS drops
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) cts_r <= 1'b0;
      else if (rtsLvl_r) cts_r <= cts_r | !holdOff;
      else cts_r <= !holdOff;
   end
   assign link.clearToSendIn = cts_r;
   // ***************************************************
   // Sender
   // ***************************************************
   logic [15:0] tCnt_r;
   logic [3:0] tBit_r; // 0 start, 1..8 data, 9 stop
   logic [7:0] tSh_r;
   logic tBusy_r, tLine_r;
   assign sendReady = !tBusy_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tCnt_r <= '0;
         tBit_r <= '0;
         tSh_r <= '0;
         tBusy_r <= 1'b0;
         tLine_r <= 1'b1;
      end else if (!tBusy_r) begin
         if (sendValid) begin
            tBusy_r <= 1'b1;
            tLine_r <= 1'b0;
            tSh_r <= sendData;
            tBit_r <= '0;
            tCnt_r <= DIVISOR;
         end
      end else if (tCnt_r != 16'h0000) tCnt_r <= tCnt_r - 16'h0001;
      else begin
         tCnt_r <= DIVISOR;
         tBit_r <= tBit_r + 4'h1;
         if (tBit_r == 4'h9) begin
            tBusy_r <= 1'b0;
            tLine_r <= 1'b1;
         end else if (tBit_r == 4'h8) tLine_r <= 1'b1;
         else begin
            tLine_r <= tSh_r[0];
            tSh_r <= {1'b0, tSh_r[7:1]};
         end
      end
   end
   assign link.serialRxLine = tLine_r;
   // ***************************************************
   // Receiver
   // ***************************************************
   logic [15:0] rCnt_r;
   logic [3:0] rBit_r;
   logic [7:0] rSh_r;
   logic rBusy_r;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rCnt_r <= '0;
         rBit_r <= '0;
         rSh_r <= '0;
         rBusy_r <= 1'b0;
         recvData <= '0;
         recvValid <= 1'b0;
         recvFrameErr <= 1'b0;
      end else begin
         recvValid <= 1'b0;
         recvFrameErr <= 1'b0;
         if (!rBusy_r) begin
            if (!dLvl_r) begin
               rBusy_r <= 1'b1;
               rBit_r <= '0;
               rCnt_r <= {1'b0, DIVISOR[15:1]};
            end
         end else if (rCnt_r != 16'h0000) rCnt_r <= rCnt_r - 16'h0001;
         else begin
            rCnt_r <= DIVISOR;
            rBit_r <= rBit_r + 4'h1;
            if (rBit_r == 4'h0 && dLvl_r) rBusy_r <= 1'b0;
            else if (rBit_r == 4'h9) begin
               rBusy_r <= 1'b0;
               recvValid <= dLvl_r;
               recvFrameErr <= !dLvl_r;
               recvData <= rSh_r;
            end else if (rBit_r != 4'h0) rSh_r <= {dLvl_r, rSh_r[7:1]};
         end
      end
   end
endmodule : fsp_peer

/* File: test/fsp_link_props.sv */
/* Link checker for the fast serial port.
 * Assumes one clock and P clocks per bit on the transmit line. */
`timescale 1ns/100ps
module fsp_link_props #(
   parameter int P = 24
)(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic serialTxLine,
   input wire logic serialRxLine,
   input wire logic clearToSendIn,
   input wire logic requestToSendOut
);
   // ********
   // Frame tracker
   // ********
   logic inFrame_r; // Transmit frame under way
   logic txPrev_r; // Line one cycle back
   int pos_r; // Cycle index within frame
   // Finds each start edge and counts cycles
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         inFrame_r <= 1'b0;
         txPrev_r <= 1'b1;
         pos_r <= 0;
      end else begin
         txPrev_r <= serialTxLine;
         if (!inFrame_r && txPrev_r && !serialTxLine) begin
            inFrame_r <= 1'b1;
            pos_r <= 1;
         end else if (inFrame_r) begin
            pos_r <= pos_r + 1;
            if (pos_r == 10 * P - 1) begin
               inFrame_r <= 1'b0;
            end
         end
      end
   end
   // ********
   // Properties
   // ********
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   chk_reset_idle_lines: assert property ($rose(arst_n) |->
      serialTxLine && serialRxLine && !requestToSendOut) else $error("lines not idle");
   chk_start_bit_low: assert property (inFrame_r && pos_r < P |-> !serialTxLine)
      else $error("start bit short");
   chk_bit_steady: assert property (inFrame_r && pos_r % P != 0 |->
      serialTxLine == $past(serialTxLine)) else $error("bit changed mid period");
   chk_stop_bit_high: assert property (inFrame_r && pos_r >= 9 * P |-> serialTxLine)
      else $error("stop bit low");
   chk_rts_third_bit: assert property ($fell(requestToSendOut) |->
      inFrame_r && pos_r >= 3 * P && pos_r <= 4 * P) else $error("rts dropped off time");
   chk_start_needs_cts: assert property ($fell(serialTxLine) && !inFrame_r &&
      requestToSendOut |-> $past(clearToSendIn, 3)) else $error("start without cts");
   chk_start_prompt: assert property ($rose(requestToSendOut) && clearToSendIn &&
      $past(clearToSendIn, 4) |-> ##[1:3] !serialTxLine) else $error("start delayed");
   chk_cts_hold_start: assert property (requestToSendOut && clearToSendIn &&
      serialTxLine |=> clearToSendIn) else $error("cts dropped early");
endmodule : fsp_link_props

/* File: test/high_speed_serial_port_test.sv */
/* Self-checking bench: port and peer joined by the link interface.
 * Assumes reset rate (24 clocks per bit) on both ends. */
`timescale 1ns/100ps
module high_speed_serial_port_test;
   localparam int P = 24; // Clocks per bit
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [15:0] regWrData = 16'h0000;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] sendData = 8'h00;
   logic sendValid = 1'b0;
   logic holdOff = 1'b0; // Peer asks port to wait
   logic [15:0] regRdData, memAddr;
   logic irq, memWrEn, sendReady, recvValid, rdPend, frameErr;
   logic [7:0] memWrData, recvData, b;
   int fail_count = 0;
   int n_checks = 0;
   int seed = 32'hf533;
   logic [15:0] rdQ[$]; // Expected read data
   logic [7:0] txQ[$]; // Expected peer bytes
   logic [15:0] memQ[$]; // Expected address low byte and data
   always #20 clk = ~clk;
   fsp_link_if link();
   fsp_device fsp_device_inst (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .irq(irq), .memWrEn(memWrEn), .memAddr(memAddr), .memWrData(memWrData), .link(link));
   fsp_peer #(.DIVISOR(16'h0017)) fsp_peer_inst (.clk(clk), .arst_n(arst_n),
      .sendData(sendData), .sendValid(sendValid), .sendReady(sendReady),
      .recvData(recvData), .recvValid(recvValid), .recvFrameErr(frameErr), .holdOff(holdOff),
      .link(link));
   fsp_link_props #(.P(P)) fsp_link_props_inst (.clk(clk), .arst_n(arst_n),
      .serialTxLine(link.serialTxLine), .serialRxLine(link.serialRxLine),
      .clearToSendIn(link.clearToSendIn), .requestToSendOut(link.requestToSendOut));
   // ********
   // Tasks
   // ********
   // Compares and counts
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   // Verdict and end of run
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : summarize
   // One-cycle register write
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(posedge clk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   // One-cycle register read, result noted
   task automatic rd(input logic [15:0] a, input logic [15:0] e);
      rdQ.push_back(e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
   endtask : rd
   // Peer sends one byte and finishes its stop bit
   task automatic send(input logic [7:0] d);
      while (sendReady !== 1'b1) @(negedge clk);
      @(posedge clk);
      sendData <= d;
      sendValid <= 1'b1;
      @(posedge clk);
      sendValid <= 1'b0;
      @(negedge clk);
      while (sendReady !== 1'b1) @(negedge clk);
   endtask : send
   // Port sends one byte; start to done span measured
   task automatic txByte(input logic [7:0] d, input int span, input bit hold);
      int n;
      n = 0;
      txQ.push_back(d);
      wr(fsp_pkg::OFF_TXDATA, {8'h00, d});
      if (hold) begin
         repeat (300) @(negedge clk);
         chk("held line", {15'h0000, link.serialTxLine}, 16'h0001);
         @(posedge clk);
         holdOff <= 1'b0;
      end
      while (link.serialTxLine !== 1'b0) @(negedge clk);
      while (irq !== 1'b1 && n < 2000) begin
         @(negedge clk);
         n++;
      end
      chk("frame span", 16'(n), 16'(span));
      wr(fsp_pkg::OFF_IRQSTAT, 16'h0002);
   endtask : txByte
   // ********
   // Result watcher
   // ********
   always @(negedge clk) begin
      if (rdPend === 1'b1) begin
         chk("read", regRdData, rdQ.pop_front());
      end
      rdPend = regRd;
      if (recvValid === 1'b1 || frameErr === 1'b1) begin
         chk("peer byte", {7'h00, frameErr, recvData}, {8'h00, txQ.pop_front()});
      end
      if (memWrEn === 1'b1) begin
         chk("mem write", {memAddr[7:0], memWrData}, memQ.pop_front());
      end
   end
   // ********
   // Main sequence
   // ********
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      rd(fsp_pkg::OFF_GAP, 16'h000b);
      rd(fsp_pkg::OFF_RATE, 16'h0017);
      rd(fsp_pkg::OFF_CTRL, 16'h0000);
      rd(16'hc0fe, 16'h0000);
      wr(fsp_pkg::OFF_IRQMASK, 16'h0002);
      // Byte, block default, block long gap, held, prompt
      for (int i = 0; i < 5; i++) begin
         wr(fsp_pkg::OFF_CTRL, (i == 0) ? 16'h0000 : (i < 3) ? 16'h0001 : 16'h0004);
         if (i == 2) begin
            wr(fsp_pkg::OFF_GAP, 16'h000c);
         end
         if (i == 3) begin
            holdOff <= 1'b1;
            repeat (10) @(posedge clk);
         end
         txByte(8'($random(seed)), (i == 1) ? 11 * P : (i == 2) ? 12 * P : 10 * P, i == 3);
      end
      // Byte mode receive, mask on and off
      wr(fsp_pkg::OFF_CTRL, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         b = 8'($random(seed));
         wr(fsp_pkg::OFF_IRQMASK, {15'h0000, i[0]});
         send(b);
         chk("rx irq", {15'h0000, irq}, {15'h0000, i[0]});
         rd(fsp_pkg::OFF_STATUS, 16'h0001);
         rd(fsp_pkg::OFF_RXDATA, {8'h00, b});
         rd(fsp_pkg::OFF_STATUS, 16'h0000);
         wr(fsp_pkg::OFF_IRQSTAT, 16'h0001);
         @(negedge clk);
         chk("irq cleared", {15'h0000, irq}, 16'h0000);
      end
      // Five bytes at a rate 4% off; the fifth finds the FIFO full
      wr(fsp_pkg::OFF_RATE, 16'h0016);
      for (int i = 0; i < 5; i++) send(8'(8'h40 + i));
      wr(fsp_pkg::OFF_RATE, 16'h0017);
      rd(fsp_pkg::OFF_IRQSTAT, 16'h0009);
      for (int i = 0; i < 4; i++) rd(fsp_pkg::OFF_RXDATA, 16'(16'h0040 + i));
      // Block mode receive straight to memory
      wr(fsp_pkg::OFF_BLKADDR, 16'h0100);
      wr(fsp_pkg::OFF_CTRL, 16'h0002);
      for (int i = 0; i < 3; i++) begin
         b = 8'($random(seed));
         memQ.push_back({i[7:0], b});
         send(b);
      end
      rd(fsp_pkg::OFF_STATUS, 16'h0000);
      rd(fsp_pkg::OFF_BLKADDR, 16'h0103);
      repeat (2) @(negedge clk);
      summarize();
   end
   // Watchdog against a hang
   initial begin
      repeat (30000) @(posedge clk);
      fail_count++;
      summarize();
   end
endmodule : high_speed_serial_port_test
